// ### core/pdcr_chan_decode.sv
// Purpose: Turns one channel's control word and routed inputs into a driver state
// Assumes: Inputs already synchronised and routed
// Notes:   Purely combinational; the top registers the results
`timescale 1ns/1ps
`include "pdcr_cfg.svh"

module pdcr_chan_decode
    import pdcr_pkg::*;
(
    // Control word
    input  wire pdcr_word_t      ctrl,
    // Routed high-speed inputs
    input  wire logic            data_in,
    input  wire logic            recv_in,
    // Decoded controls
    output pdcr_drv_state_t      drv_state,
    output logic                 clc_enable,
    output logic [2:0]           clc_strength
);

    logic             enable;
    logic             force_on;
    logic             term_float;
    pdcr_force_code_t fcode;

    assign enable     = ctrl[`PDCR_ENABLE];
    assign force_on   = ctrl[`PDCR_FORCE];
    assign term_float = ctrl[`PDCR_TERM_FLOAT];
    assign fcode      = pdcr_force_code_t'(ctrl[`PDCR_FSTATE_MSB:`PDCR_FSTATE_LSB]);

    // ****************************************
    // Pre-emphasis
    // ****************************************
    always_comb begin
        clc_strength = ctrl[`PDCR_CLC_MSB:`PDCR_CLC_LSB]; // R4
        clc_enable   = enable && (clc_strength != `PDCR_CLC_OFF); // R5
    end

    // ****************************************
    // Driver truth table
    // ****************************************
    always_comb begin
        if (!enable) begin
            drv_state = PDCR_DRV_OFF; // R10
        end else if (force_on) begin
            unique case (fcode) // R7 R8 R9
                PDCR_FRC_LOW:  drv_state = PDCR_DRV_LOW;
                PDCR_FRC_HIGH: drv_state = PDCR_DRV_HIGH;
                PDCR_FRC_TERM: drv_state = PDCR_DRV_TERM;
                PDCR_FRC_HIZ:  drv_state = PDCR_DRV_HIZ;
            endcase
        end else if (recv_in) begin
            drv_state = term_float ? PDCR_DRV_HIZ : PDCR_DRV_TERM; // R6 R11
        end else begin
            drv_state = data_in ? PDCR_DRV_HIGH : PDCR_DRV_LOW; // R11
        end
    end

endmodule

// ### core/pdcr_top.sv
// Purpose: Per-channel driver control register and driver state decode, two channels
// Assumes: Register accesses arrive as single-cycle strobes from the serial port logic on CLK_SYS
// Notes:   High-speed inputs are asynchronous and pass a two-stage synchroniser
//
// Function
// R1 - The 16-bit driver control word sits at address 0x19 with its own copy for channel 0 and channel 1.
// R2 - Bits 15:14 route the data input, clear takes the own channel and set takes the other channel.
// R3 - Bits 13:12 route the receive input, clear takes the own channel and set takes the other channel.
// R4 - Bits 11:9 set the cable-loss pre-emphasis strength from minimum at 001 up to 111.
// R5 - A cable-loss field of 000 applies no pre-emphasis while any other value enables it when bit 0 is set.
// R6 - Bit 4 picks termination when clear or high impedance when set while the receive input is high.
// R7 - Bits 3:2 pick the forced state: low, high, termination or high impedance.
// R8 - Bit 1 set forces the driver to the chosen state and ignores the data and receive inputs.
// R9 - Forcing acts only while enabled and overrides bit 4 and both high-speed inputs.
// R10 - Bit 0 clear holds the driver disabled in low leakage regardless of everything else.
// R11 - Bit 0 set lets the driver follow bit 4, the force controls and the inputs per the truth table.
// R12 - Bits 8:5 are reserved, should be written as zero and always read as zero.
`timescale 1ns/1ps
`include "pdcr_cfg.svh"

module pdcr_top
    import pdcr_pkg::*;
(
    // Clock and reset
    input  wire logic                    CLK_SYS,
    input  wire logic                    RST_N,
    // Register access from the serial port logic
    input  wire logic                    CFG_WR,
    input  wire logic                    CFG_RD,
    input  wire logic [`PDCR_ADDR_W-1:0] CFG_ADDR,
    input  wire logic [1:0]              CFG_CH_SEL,
    input  wire logic [15:0]             CFG_WDATA,
    output logic [15:0]                  CFG_RDATA,
    output logic                         CFG_RVALID,
    // High-speed inputs from the pattern formatter
    input  wire logic [1:0]              HS_DATA_IN,
    input  wire logic [1:0]              HS_RECEIVE_IN,
    // Driver controls, channel 0
    output logic [4:0]                   DRV_STATE_0,
    output logic                         CLC_EN_0,
    output logic [2:0]                   CABLE_LOSS_STRENGTH_0,
    // Driver controls, channel 1
    output logic [4:0]                   DRV_STATE_1,
    output logic                         CLC_EN_1,
    output logic [2:0]                   CABLE_LOSS_STRENGTH_1
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic hit(input logic [`PDCR_ADDR_W-1:0] a);
        hit = (a == `PDCR_DRIVER_CONTROL); // R1
    endfunction

    function automatic logic pick(input logic [1:0] v, input int unsigned ch, input logic other);
        pick = other ? v[1-ch] : v[ch];
    endfunction

    // ****************************************
    // Control registers
    // ****************************************
    pdcr_word_t ctrl_q [2];
    pdcr_word_t ctrl_d [2];

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            ctrl_d[c] = ctrl_q[c];
            if (CFG_WR && hit(CFG_ADDR) && CFG_CH_SEL[c]) begin
                ctrl_d[c] = CFG_WDATA & `PDCR_CTRL_WMASK; // R1 R12
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q[0] <= `PDCR_CTRL_RESET;
            ctrl_q[1] <= `PDCR_CTRL_RESET;
        end else begin
            ctrl_q[0] <= ctrl_d[0];
            ctrl_q[1] <= ctrl_d[1];
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic        rvalid_q;
    logic        rvalid_d;

    always_comb begin
        rvalid_d = CFG_RD;
        rdata_d  = rdata_q;
        if (CFG_RD) begin
            if (!hit(CFG_ADDR)) begin
                rdata_d = 16'h0000;
            end else if (CFG_CH_SEL[0]) begin
                rdata_d = ctrl_q[0]; // R12
            end else begin
                rdata_d = ctrl_q[1]; // R12
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q  <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign CFG_RDATA  = rdata_q;
    assign CFG_RVALID = rvalid_q;

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [1:0] dat_s1_q;
    logic [1:0] dat_s2_q;
    logic [1:0] rcv_s1_q;
    logic [1:0] rcv_s2_q;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            dat_s1_q <= 2'h0;
            dat_s2_q <= 2'h0;
            rcv_s1_q <= 2'h0;
            rcv_s2_q <= 2'h0;
        end else begin
            dat_s1_q <= HS_DATA_IN;
            dat_s2_q <= dat_s1_q;
            rcv_s1_q <= HS_RECEIVE_IN;
            rcv_s2_q <= rcv_s1_q;
        end
    end

    // ****************************************
    // Routing and decode per channel
    // ****************************************
    logic [1:0]      dat_route;
    logic [1:0]      rcv_route;
    pdcr_drv_state_t state_c [2];
    logic [1:0]      clc_en_c;
    logic [2:0]      clc_str_c [2];

    for (genvar g = 0; g < 2; g++) begin : g_ch
        assign dat_route[g] = pick(dat_s2_q, g, ctrl_q[g][`PDCR_DAT_ROUTE_SEL]); // R2
        assign rcv_route[g] = pick(rcv_s2_q, g, ctrl_q[g][`PDCR_RCV_ROUTE_SEL]); // R3

        pdcr_chan_decode u_dec (
            .ctrl         (ctrl_q[g]),
            .data_in      (dat_route[g]),
            .recv_in      (rcv_route[g]),
            .drv_state    (state_c[g]),
            .clc_enable   (clc_en_c[g]),
            .clc_strength (clc_str_c[g])
        );
    end

    // ****************************************
    // Output registers
    // ****************************************
    pdcr_drv_state_t st0_q;
    pdcr_drv_state_t st1_q;
    logic [1:0]      clc_en_q;
    logic [2:0]      str0_q;
    logic [2:0]      str1_q;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            st0_q    <= PDCR_DRV_OFF; // R10
            st1_q    <= PDCR_DRV_OFF; // R10
            clc_en_q <= 2'h0;
            str0_q   <= 3'h0;
            str1_q   <= 3'h0;
        end else begin
            st0_q    <= state_c[0];
            st1_q    <= state_c[1];
            clc_en_q <= clc_en_c;
            str0_q   <= clc_str_c[0];
            str1_q   <= clc_str_c[1];
        end
    end

    assign DRV_STATE_0           = st0_q;
    assign DRV_STATE_1           = st1_q;
    assign CLC_EN_0              = clc_en_q[0];
    assign CLC_EN_1              = clc_en_q[1];
    assign CABLE_LOSS_STRENGTH_0 = str0_q;
    assign CABLE_LOSS_STRENGTH_1 = str1_q;

endmodule

// ### include/pdcr_cfg.svh
// Purpose: Addresses, field positions and reset values of the driver control register
// Assumes: One 16-bit word per channel at the same address
// Notes:   Definitions only
`ifndef PDCR_CFG_SVH
`define PDCR_CFG_SVH

// ****************************************
// Address map
// ****************************************
`define PDCR_ADDR_W           7
`define PDCR_DRIVER_CONTROL   7'h19

// ****************************************
// Field positions
// ****************************************
`define PDCR_DAT_ROUTE_HI     15
`define PDCR_DAT_ROUTE_SEL    14
`define PDCR_RCV_ROUTE_HI     13
`define PDCR_RCV_ROUTE_SEL    12
`define PDCR_CLC_MSB          11
`define PDCR_CLC_LSB          9
`define PDCR_RSVD_MSB         8
`define PDCR_RSVD_LSB         5
`define PDCR_TERM_FLOAT       4
`define PDCR_FSTATE_MSB       3
`define PDCR_FSTATE_LSB       2
`define PDCR_FORCE            1
`define PDCR_ENABLE           0

// ****************************************
// Reset and masks
// ****************************************
`define PDCR_CTRL_RESET       16'h0000
`define PDCR_CTRL_WMASK       16'hfe1f
`define PDCR_CLC_OFF          3'h0

`endif

// ### include/pdcr_pkg.sv
// Purpose: Types shared by the driver control register block
// Assumes: Constants live in pdcr_cfg.svh
// Notes:   Driver state is one-hot
package pdcr_pkg;

    // ****************************************
    // Driver output states
    // ****************************************
    typedef enum logic [4:0] {
        PDCR_DRV_OFF  = 5'h01,
        PDCR_DRV_LOW  = 5'h02,
        PDCR_DRV_HIGH = 5'h04,
        PDCR_DRV_TERM = 5'h08,
        PDCR_DRV_HIZ  = 5'h10
    } pdcr_drv_state_t;

    // ****************************************
    // Forced-state field codes
    // ****************************************
    typedef enum logic [1:0] {
        PDCR_FRC_LOW  = 2'h0,
        PDCR_FRC_HIGH = 2'h1,
        PDCR_FRC_TERM = 2'h2,
        PDCR_FRC_HIZ  = 2'h3
    } pdcr_force_code_t;

    typedef logic [15:0] pdcr_word_t;

endpackage

// ### sim/pdcr_fmt_model.sv
// Purpose: Pattern formatter model driving the high-speed inputs
// Assumes: Levels change just after a rising clock edge
// Notes:   Both lines are push-pull and always driven
`timescale 1ns/1ps
module pdcr_fmt_model (
    // Clock
    input  wire logic       clk,
    // Pattern levels, bit index is channel
    output logic [1:0]      data_out,
    output logic [1:0]      recv_out
);
    initial begin
        data_out = 2'h0;
        recv_out = 2'h0;
    end
    task automatic drive(input logic [1:0] d, input logic [1:0] r);
        @(posedge clk);
        data_out <= d;
        recv_out <= r;
    endtask
endmodule

// ### sim/pdcr_top_assertions.sv
// Purpose: Port checks on the driver control register block
// Assumes: One clock domain, reset low active
// Notes:   Bound to every pdcr_top
`timescale 1ns/1ps
`include "pdcr_cfg.svh"
module pdcr_top_assertions
    import pdcr_pkg::*;
(
    // Clock, reset and register port
    input  wire logic                    CLK_SYS,
    input  wire logic                    RST_N,
    input  wire logic                    CFG_RD,
    input  wire logic [`PDCR_ADDR_W-1:0] CFG_ADDR,
    input  wire logic [15:0]             CFG_RDATA,
    input  wire logic                    CFG_RVALID,
    // Driver controls
    input  wire logic [4:0]              DRV_STATE_0,
    input  wire logic                    CLC_EN_0,
    input  wire logic [2:0]              CABLE_LOSS_STRENGTH_0,
    input  wire logic [4:0]              DRV_STATE_1,
    input  wire logic                    CLC_EN_1,
    input  wire logic [2:0]              CABLE_LOSS_STRENGTH_1
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    chk_read_answer: assert property (CFG_RD |=> CFG_RVALID)
        else $error("read not answered");
    chk_rvalid_cause: assert property (CFG_RVALID |-> $past(CFG_RD))
        else $error("answer without read");
    chk_unmapped_zero: assert property (CFG_RD && CFG_ADDR != 7'h19 |=> CFG_RDATA == 16'h0000)
        else $error("unmapped read not zero");
    chk_rsvd_zero: assert property (CFG_RVALID |-> CFG_RDATA[8:5] == 4'h0)
        else $error("reserved bits read nonzero");
    chk_rdata_hold: assert property (!CFG_RVALID |-> $stable(CFG_RDATA))
        else $error("read data moved");
    chk_state_onehot: assert property ($onehot(DRV_STATE_0) && $onehot(DRV_STATE_1))
        else $error("driver state not one-hot");
    chk_clc_ch0: assert property (CLC_EN_0 == (CABLE_LOSS_STRENGTH_0 != 3'h0 && DRV_STATE_0 != 5'h01))
        else $error("ch0 pre-emphasis enable wrong");
    chk_clc_ch1: assert property (CLC_EN_1 == (CABLE_LOSS_STRENGTH_1 != 3'h0 && DRV_STATE_1 != 5'h01))
        else $error("ch1 pre-emphasis enable wrong");
    cover property (CFG_RVALID && CFG_RDATA != 16'h0000);
    cover property (DRV_STATE_0 == 5'h10);
    cover property (CLC_EN_1);
endmodule
bind pdcr_top pdcr_top_assertions u_pdcr_top_assertions (.CLK_SYS, .RST_N, .CFG_RD, .CFG_ADDR, .CFG_RDATA,
    .CFG_RVALID, .DRV_STATE_0, .CLC_EN_0, .CABLE_LOSS_STRENGTH_0, .DRV_STATE_1, .CLC_EN_1, .CABLE_LOSS_STRENGTH_1);

// ### sim/tb_top.sv
// Purpose: Register and driver state tests for pdcr_top
// Assumes: Strobe register port, formatter model on the high-speed inputs
// Notes:   Waits of four edges cover the three-edge input path
`timescale 1ns/1ps
module tb_top
    import pdcr_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, rv, ce0, ce1;
    logic [6:0]  addr = 7'h19;
    logic [1:0]  sel = 2'h1, hd, hr;
    logic [15:0] wd = 16'h0000, rdat;
    logic [4:0]  d0, d1;
    logic [2:0]  s0, s1;
    logic [4:0]  frc [4] = '{5'h02, 5'h04, 5'h08, 5'h10};
    int          num_errors = 0, tests_run = 0;
    always #12.5 clk = ~clk;
    pdcr_fmt_model u_pdcr_fmt_model (.clk(clk), .data_out(hd), .recv_out(hr));
    pdcr_top u_pdcr_top (.CLK_SYS(clk), .RST_N(rst_n), .CFG_WR(wr_s), .CFG_RD(rd_s), .CFG_ADDR(addr),
        .CFG_CH_SEL(sel), .CFG_WDATA(wd), .CFG_RDATA(rdat), .CFG_RVALID(rv), .HS_DATA_IN(hd),
        .HS_RECEIVE_IN(hr), .DRV_STATE_0(d0), .CLC_EN_0(ce0), .CABLE_LOSS_STRENGTH_0(s0),
        .DRV_STATE_1(d1), .CLC_EN_1(ce1), .CABLE_LOSS_STRENGTH_1(s1));
    // ****************************************
    // Access and compare tasks
    // ****************************************
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [1:0] c, input logic [15:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        sel <= c;
        wd <= d;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [1:0] c, input logic [15:0] e);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        sel <= c;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk("rvalid", {15'h0, rv}, 16'h0001);
        chk("rdata", rdat, e);
    endtask
    task automatic st(input logic [1:0] d, input logic [1:0] r);
        u_pdcr_fmt_model.drive(d, r);
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic dv(input logic [4:0] e0, input logic [4:0] e1);
        chk("state0", {11'h0, d0}, {11'h0, e0});
        chk("state1", {11'h0, d1}, {11'h0, e1});
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        #50000;
        num_errors++;
        end_of_test;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(7'h19, 2'h1, 16'h0000);
        dv(5'h01, 5'h01);
        $display("test reset done");
        wr(7'h19, 2'h3, 16'hffff);
        rd(7'h19, 2'h1, 16'hfe1f);
        rd(7'h19, 2'h2, 16'hfe1f);
        st(2'h0, 2'h0);
        dv(5'h10, 5'h10);
        wr(7'h18, 2'h3, 16'h0000);
        wr(7'h19, 2'h0, 16'h0000);
        rd(7'h18, 2'h1, 16'h0000);
        rd(7'h19, 2'h1, 16'hfe1f);
        $display("test regs done");
        wr(7'h19, 2'h3, 16'h0001);
        st(2'h1, 2'h0);
        dv(5'h04, 5'h02);
        st(2'h2, 2'h1);
        dv(5'h08, 5'h04);
        wr(7'h19, 2'h1, 16'h0011);
        st(2'h2, 2'h1);
        dv(5'h10, 5'h04);
        wr(7'h19, 2'h1, 16'h0010);
        st(2'h3, 2'h3);
        dv(5'h01, 5'h08);
        $display("test truth done");
        wr(7'h19, 2'h2, 16'h5001);
        st(2'h1, 2'h0);
        dv(5'h01, 5'h04);
        st(2'h2, 2'h0);
        dv(5'h01, 5'h02);
        st(2'h2, 2'h1);
        dv(5'h01, 5'h08);
        $display("test route done");
        for (int k = 0; k < 4; k++) begin
            wr(7'h19, 2'h3, {12'h0, k[1:0], 2'h3});
            st(2'h3, 2'h3);
            dv(frc[k], frc[k]);
        end
        wr(7'h19, 2'h3, 16'h001b);
        st(2'h1, 2'h3);
        dv(5'h08, 5'h08);
        wr(7'h19, 2'h3, 16'h001e);
        st(2'h3, 2'h3);
        dv(5'h01, 5'h01);
        $display("test force done");
        for (int c = 0; c < 8; c++) begin
            wr(7'h19, 2'h1, {4'h0, c[2:0], 9'h001});
            st(2'h0, 2'h0);
            chk("strength0", {13'h0, s0}, {13'h0, c[2:0]});
            chk("clc0", {15'h0, ce0}, {15'h0, c != 0});
        end
        wr(7'h19, 2'h2, 16'h0e00);
        st(2'h0, 2'h0);
        chk("strength1", {13'h0, s1}, 16'h0007);
        chk("clc1", {15'h0, ce1}, 16'h0000);
        wr(7'h19, 2'h2, 16'h0601);
        st(2'h0, 2'h0);
        chk("strength1", {13'h0, s1}, 16'h0003);
        chk("clc1", {15'h0, ce1}, 16'h0001);
        chk("state1", {11'h0, d1}, 16'h0002);
        $display("test clc done");
        end_of_test;
    end
endmodule
